// file: dv/rdt_host.sv
// Host model driving the register strobe port
`timescale 1ns/1ps
module rdt_host (
	// Clock
	input wire logic core_clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	output logic crit_override
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
		crit_override = 1'b0;
	end
	// One strobe, then scrambled address and data
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = wr;
		reg_rd = !wr;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : xfer
	task automatic cfg(input logic [1:0] f, input logic c);
		xfer(1'b1, 8'hBF, {5'h00, f, c});
	endtask : cfg
	task automatic ovr(input logic v);
		@(negedge core_clk);
		crit_override = v;
	endtask : ovr
endmodule : rdt_host

// file: dv/rdt_limits_props.sv
// Checker for the remote temperature limit registers
`timescale 1ns/1ps
module rdt_limits_props
	import rdt_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Sample and alarms
	input wire logic adc_valid,
	input wire logic crit_override,
	input wire logic alert_normal,
	input wire logic remote_high_alarm,
	input wire logic remote_low_alarm,
	input wire logic remote_crit_alarm,
	input wire logic alert_condition,
	input wire logic alert_pin_o,
	input wire logic alert_pin_oe
);
	logic cmp_mode;
	logic crit_lock;
	logic [7:0] crit_val;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmp_mode <= 1'b0;
			crit_lock <= 1'b0;
			crit_val <= RDT_RST_CRIT_LIMIT;
		end else if (reg_wr) begin
			if (reg_addr == RDT_OFS_FILTER_PIN)
				cmp_mode <= reg_wdata[RDT_CMP_BIT];
			if (reg_addr == RDT_OFS_CRIT_LIMIT && crit_override && !crit_lock) begin
				crit_lock <= 1'b1;
				crit_val <= reg_wdata;
			end
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	chk_pin_low: assert property (alert_pin_o == 1'b0) else $error("pin output high");
	chk_pin_select: assert property (
		alert_pin_oe == (cmp_mode ? alert_condition : alert_normal)) else $error("pin enable");
	chk_cond_or: assert property (
		alert_condition == (remote_high_alarm | remote_low_alarm | remote_crit_alarm))
		else $error("alert condition");
	chk_frac_zero: assert property (
		reg_rd && reg_addr inside {8'h10, 8'h12, 8'h13, 8'h14} |=> reg_rdata[4:0] == 5'h00)
		else $error("fraction low bits");
	chk_cfg_upper: assert property (
		reg_rd && reg_addr == RDT_OFS_FILTER_PIN |=> reg_rdata[7:3] == 5'h00) else $error("cfg");
	chk_crit_once: assert property (
		reg_rd && reg_addr == RDT_OFS_CRIT_LIMIT |=> reg_rdata == $past(crit_val))
		else $error("critical limit");
	chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata");
	chk_alarm_sample: assert property (
		$changed({remote_high_alarm, remote_low_alarm, remote_crit_alarm}) |-> $past(adc_valid, 2))
		else $error("alarm change");
	cov_crit: cover property (remote_crit_alarm && remote_high_alarm);
	cov_low: cover property (remote_low_alarm);
	cov_cmp_pin: cover property (cmp_mode && alert_pin_oe);
endmodule : rdt_limits_props
bind rdt_limits rdt_limits_props i_rdt_limits_props (.core_clk(core_clk), .arst_n(arst_n),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .adc_valid(adc_valid), .crit_override(crit_override),
	.alert_normal(alert_normal), .remote_high_alarm(remote_high_alarm),
	.remote_low_alarm(remote_low_alarm), .remote_crit_alarm(remote_crit_alarm),
	.alert_condition(alert_condition), .alert_pin_o(alert_pin_o), .alert_pin_oe(alert_pin_oe));

// file: dv/rdt_limits_test.sv
// Self-checking bench for the remote temperature limit registers
`timescale 1ns/1ps
module rdt_limits_test
	import rdt_pkg::*;
;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [7:0] exp_q[$];
	logic reg_wr, reg_rd, crit_override, hi, lo, cr, cond, rvalid, pin_o, pin_oe;
	logic adc_valid = 1'b0;
	logic alert_normal = 1'b0;
	logic rd_seen = 1'b0;
	logic [RDT_TEMP_W-1:0] adc_temp = '0;
	int n_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	always #50 core_clk = ~core_clk;
	rdt_host i_rdt_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .crit_override(crit_override));
	rdt_limits i_rdt_limits (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.adc_valid(adc_valid), .adc_temp(adc_temp), .crit_override(crit_override),
		.alert_normal(alert_normal), .remote_high_alarm(hi), .remote_low_alarm(lo),
		.remote_crit_alarm(cr), .alert_condition(cond), .reading_valid(rvalid),
		.alert_pin_o(pin_o), .alert_pin_oe(pin_oe));
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	always @(posedge core_clk) begin
		rd_seen <= reg_rd;
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			stop_test();
		end
	end
	always @(negedge core_clk) begin
		if (rd_seen)
			check("reg_rdata", reg_rdata, exp_q.pop_front());
	end
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_rdt_host.xfer(1'b0, a, 8'h00);
	endtask : rd
	task automatic sample(input logic [10:0] t);
		@(negedge core_clk);
		adc_valid = 1'b1;
		adc_temp = t;
		@(negedge core_clk);
		adc_valid = 1'b0;
		adc_temp = ~t;
		repeat (2) @(negedge core_clk);
	endtask : sample
	logic [7:0] ra[11] = '{8'h07, 8'h13, 8'h08, 8'h14, 8'h11, 8'h12, 8'h19, 8'h21, 8'hBF, 8'h10, 8'h55};
	logic [7:0] rv[11] = '{8'h46, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'h0A, 8'h00, 8'h00, 8'h00};
	logic [7:0] wa[5] = '{8'h07, 8'h13, 8'h08, 8'h14, 8'h21};
	byte tt[8] = '{20, 5, 35, 41, 36, 34, 40, -3};
	logic [2:0] te[8] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h5, 3'h4, 3'h4, 3'h2};
	logic [1:0] fm[4] = '{2'b00, 2'b01, 2'b10, 2'b11};
	logic [10:0] ft[4] = '{11'h000, 11'h040, 11'h040, 11'h0B0};
	logic [7:0] fe[4] = '{8'h00, 8'h04, 8'h06, 8'h08};
	initial begin
		logic [7:0] r, o;
		logic [10:0] t, s;
		void'($urandom(32'h34e1));
		repeat (20) @(negedge core_clk);
		arst_n = 1'b1;
		check("reading_valid", {7'h00, rvalid}, 8'h00);
		foreach (ra[i]) rd(ra[i], rv[i]);
		$display("reset values done");
		foreach (wa[i]) begin
			r = 8'($urandom);
			i_rdt_host.xfer(1'b1, wa[i], r);
			rd(wa[i], wa[i][4] ? (r & 8'hE0) : r);
		end
		for (int m = 0; m < 4; m++) begin
			i_rdt_host.cfg(2'(m), 1'(m));
			rd(8'hBF, {5'h00, 2'(m), 1'(m)});
		end
		i_rdt_host.cfg(2'b00, 1'b0);
		$display("register access done");
		repeat (4) begin
			o = 8'($urandom_range(15)) - 8'h08;
			r = {3'($urandom), 5'h00};
			t = {8'($urandom_range(80)) - 8'd40, 3'($urandom)};
			s = t + {o, r[7:5]};
			i_rdt_host.xfer(1'b1, 8'h11, o);
			i_rdt_host.xfer(1'b1, 8'h12, r);
			sample(t);
			rd(8'h01, s[10:3]);
			rd(8'h10, {s[2:0], 5'h00});
			sample(t ^ 11'h005);
			rd(8'h10, {s[2:0], 5'h00});
		end
		i_rdt_host.xfer(1'b1, 8'h11, 8'h00);
		i_rdt_host.xfer(1'b1, 8'h12, 8'h00);
		$display("offset reading done");
		// Pass-through seed, then half, half and eighth steps
		foreach (fm[i]) begin
			i_rdt_host.cfg(fm[i], 1'b0);
			sample(ft[i]);
			rd(8'h01, fe[i]);
		end
		$display("filter modes done");
		i_rdt_host.xfer(1'b1, 8'h19, 8'h20);
		rd(8'h19, 8'h55);
		i_rdt_host.ovr(1'b1);
		i_rdt_host.xfer(1'b1, 8'h19, 8'h28);
		i_rdt_host.xfer(1'b1, 8'h19, 8'h50);
		rd(8'h19, 8'h28);
		i_rdt_host.ovr(1'b0);
		// Reset in mid-run unlocks the critical limit again
		@(negedge core_clk);
		arst_n = 1'b0;
		repeat (3) @(negedge core_clk);
		arst_n = 1'b1;
		check("reading_valid", {7'h00, rvalid}, 8'h00);
		rd(8'h19, 8'h55);
		i_rdt_host.ovr(1'b1);
		i_rdt_host.xfer(1'b1, 8'h19, 8'h28);
		rd(8'h19, 8'h28);
		i_rdt_host.ovr(1'b0);
		$display("critical lock done");
		i_rdt_host.xfer(1'b1, 8'h07, 8'h1E);
		i_rdt_host.xfer(1'b1, 8'h13, 8'h00);
		i_rdt_host.xfer(1'b1, 8'h08, 8'h0A);
		i_rdt_host.xfer(1'b1, 8'h14, 8'h00);
		i_rdt_host.xfer(1'b1, 8'h21, 8'h05);
		foreach (tt[i]) begin
			i_rdt_host.cfg(2'b00, 1'(i));
			alert_normal = 1'($urandom);
			sample({tt[i], 3'h0});
			check("alarms", {5'h00, hi, lo, cr}, {5'h00, te[i]});
			check("pin", {7'h00, pin_oe}, {7'h00, i[0] ? |te[i] : alert_normal});
		end
		check("reading_valid", {7'h00, rvalid}, 8'h01);
		$display("alarms done");
		stop_test();
	end
endmodule : rdt_limits_test

// file: rtl/rdt_cmp.sv
// Signed magnitude comparator of two temperatures
`timescale 1ns/1ps
module rdt_cmp #(
	parameter int W = 11
) (
	// Operands
	input wire logic [W-1:0] lhs,
	input wire logic [W-1:0] rhs,
	// Results
	output logic above,
	output logic below
);
	always_comb begin
		above = $signed(lhs) > $signed(rhs);
		below = $signed(lhs) < $signed(rhs);
	end
endmodule : rdt_cmp

// file: rtl/rdt_filter.sv
// Smoothing filter on the offset-corrected remote temperature
`timescale 1ns/1ps
module rdt_filter
	import rdt_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Sample in
	input wire logic in_valid,
	input wire logic [RDT_TEMP_W-1:0] in_temp,
	input wire logic [1:0] mode,
	// Filtered sample out
	output logic out_valid,
	output logic [RDT_TEMP_W-1:0] out_temp
);
	typedef struct packed {
		logic seeded;
		logic valid;
		logic [RDT_TEMP_W-1:0] acc;
	} rdt_filt_s;

	rdt_filt_s st;
	rdt_filt_s next_st;
	logic signed [RDT_TEMP_W:0] diff;
	logic signed [RDT_TEMP_W:0] step;

	always_comb begin
		next_st = st;
		next_st.valid = 1'b0;
		diff = $signed({in_temp[RDT_TEMP_W-1], in_temp}) - $signed({st.acc[RDT_TEMP_W-1], st.acc});
		// Minimal and maximum filtering differ only in the smoothing shift
		case (rdt_filt_e'(mode))
			RDT_FILT_MIN_A, RDT_FILT_MIN_B: step = diff >>> RDT_FILT_MIN_SHIFT;
			RDT_FILT_MAX: step = diff >>> RDT_FILT_MAX_SHIFT;
			default: step = diff;
		endcase
		if (in_valid) begin
			next_st.valid = 1'b1;
			next_st.seeded = 1'b1;
			if (!st.seeded || rdt_filt_e'(mode) == RDT_FILT_OFF) begin
				next_st.acc = in_temp;
			end else begin
				next_st.acc = st.acc + step[RDT_TEMP_W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign out_valid = st.valid;
	assign out_temp = st.acc;
endmodule : rdt_filter

// file: rtl/rdt_limits.sv
// Remote temperature result, offset, setpoint and critical-trip registers
`timescale 1ns/1ps
module rdt_limits
	import rdt_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Converter result
	input wire logic adc_valid,
	input wire logic [RDT_TEMP_W-1:0] adc_temp,
	// Configuration override bit
	input wire logic crit_override,
	// Normal-mode alert request from status logic
	input wire logic alert_normal,
	// Alarm conditions to status logic
	output logic remote_high_alarm,
	output logic remote_low_alarm,
	output logic remote_crit_alarm,
	output logic alert_condition,
	output logic reading_valid,
	// Shared alert/fan-pulse pin, open drain
	output logic alert_pin_o,
	output logic alert_pin_oe
);
	typedef struct packed {
		logic [RDT_TEMP_W-1:0] reading;
		logic [RDT_FRAC_W-1:0] frac_shadow;
		logic [7:0] offset_int;
		logic [RDT_FRAC_W-1:0] offset_frac;
		logic [7:0] high_int;
		logic [RDT_FRAC_W-1:0] high_frac;
		logic [7:0] low_int;
		logic [RDT_FRAC_W-1:0] low_frac;
		logic [7:0] crit_limit;
		logic crit_locked;
		logic [7:0] crit_hyst;
		logic [1:0] filter_mode;
		logic cmp_mode;
		logic high_alarm;
		logic low_alarm;
		logic crit_alarm;
		logic valid;
		logic [7:0] rdata;
	} rdt_lim_s;

	rdt_lim_s st;
	rdt_lim_s next_st;

	logic [RDT_TEMP_W-1:0] offset_full;
	logic [RDT_TEMP_W:0] sum_wide;
	logic [RDT_TEMP_W-1:0] corrected;
	logic filt_valid;
	logic [RDT_TEMP_W-1:0] filt_temp;
	logic [RDT_TEMP_W-1:0] high_full;
	logic [RDT_TEMP_W-1:0] low_full;
	logic [RDT_TEMP_W-1:0] crit_full;
	logic [RDT_TEMP_W:0] release_full;
	logic above_high;
	logic below_high;
	logic above_low;
	logic below_low;
	logic above_crit;
	logic below_crit;
	logic above_rel;
	logic below_rel;

	// Offset added to converter output with saturation
	always_comb begin
		offset_full = {st.offset_int, st.offset_frac};
		sum_wide = {adc_temp[RDT_TEMP_W-1], adc_temp} + {offset_full[RDT_TEMP_W-1], offset_full};
		if (sum_wide[RDT_TEMP_W] != sum_wide[RDT_TEMP_W-1]) begin
			corrected = sum_wide[RDT_TEMP_W] ? {1'b1, {(RDT_TEMP_W-1){1'b0}}}
				: {1'b0, {(RDT_TEMP_W-1){1'b1}}};
		end else begin
			corrected = sum_wide[RDT_TEMP_W-1:0];
		end
	end

	rdt_filter u_filter (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.in_valid(adc_valid),
		.in_temp(corrected),
		.mode(st.filter_mode),
		.out_valid(filt_valid),
		.out_temp(filt_temp)
	);

	// Limits widened to the reading format
	always_comb begin
		high_full = {st.high_int, st.high_frac};
		low_full = {st.low_int, st.low_frac};
		crit_full = {st.crit_limit, {RDT_FRAC_W{1'b0}}};
		release_full = {st.crit_limit[7], st.crit_limit, {RDT_FRAC_W{1'b0}}}
			- {1'b0, st.crit_hyst, {RDT_FRAC_W{1'b0}}};
	end

	rdt_cmp #(.W(RDT_TEMP_W)) u_cmp_high (
		.lhs(filt_temp),
		.rhs(high_full),
		.above(above_high),
		.below(below_high)
	);

	rdt_cmp #(.W(RDT_TEMP_W)) u_cmp_low (
		.lhs(filt_temp),
		.rhs(low_full),
		.above(above_low),
		.below(below_low)
	);

	rdt_cmp #(.W(RDT_TEMP_W)) u_cmp_crit (
		.lhs(filt_temp),
		.rhs(crit_full),
		.above(above_crit),
		.below(below_crit)
	);

	rdt_cmp #(.W(RDT_TEMP_W + 1)) u_cmp_release (
		.lhs({filt_temp[RDT_TEMP_W-1], filt_temp}),
		.rhs(release_full),
		.above(above_rel),
		.below(below_rel)
	);

	always_comb begin
		next_st = st;
		// New filtered result updates reading and alarm levels
		if (filt_valid) begin
			next_st.reading = filt_temp;
			next_st.valid = 1'b1;
			next_st.high_alarm = above_high;
			next_st.low_alarm = below_low;
			if (above_crit) begin
				next_st.crit_alarm = 1'b1;
			end else if (below_rel) begin
				next_st.crit_alarm = 1'b0;
			end
		end
		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				RDT_OFS_OFFSET_INT: next_st.offset_int = reg_wdata;
				RDT_OFS_OFFSET_FRAC: next_st.offset_frac = reg_wdata[RDT_FRAC_MSB:RDT_FRAC_LSB];
				RDT_OFS_HIGH_INT: next_st.high_int = reg_wdata;
				RDT_OFS_HIGH_FRAC: next_st.high_frac = reg_wdata[RDT_FRAC_MSB:RDT_FRAC_LSB];
				RDT_OFS_LOW_INT: next_st.low_int = reg_wdata;
				RDT_OFS_LOW_FRAC: next_st.low_frac = reg_wdata[RDT_FRAC_MSB:RDT_FRAC_LSB];
				RDT_OFS_CRIT_LIMIT: begin
					if (crit_override && !st.crit_locked) begin
						next_st.crit_limit = reg_wdata;
						next_st.crit_locked = 1'b1;
					end
				end
				RDT_OFS_CRIT_HYST: next_st.crit_hyst = reg_wdata;
				RDT_OFS_FILTER_PIN: begin
					next_st.filter_mode = reg_wdata[RDT_FILT_MSB:RDT_FILT_LSB];
					next_st.cmp_mode = reg_wdata[RDT_CMP_BIT];
				end
				default: ;
			endcase
		end
		// Register reads, answer one cycle later
		if (reg_rd) begin
			case (reg_addr)
				RDT_OFS_READING_INT: begin
					next_st.rdata = st.reading[RDT_TEMP_W-1:RDT_FRAC_W];
					next_st.frac_shadow = st.reading[RDT_FRAC_W-1:0];
				end
				RDT_OFS_READING_FRAC: next_st.rdata = {st.frac_shadow, 5'h00};
				RDT_OFS_OFFSET_INT: next_st.rdata = st.offset_int;
				RDT_OFS_OFFSET_FRAC: next_st.rdata = {st.offset_frac, 5'h00};
				RDT_OFS_HIGH_INT: next_st.rdata = st.high_int;
				RDT_OFS_HIGH_FRAC: next_st.rdata = {st.high_frac, 5'h00};
				RDT_OFS_LOW_INT: next_st.rdata = st.low_int;
				RDT_OFS_LOW_FRAC: next_st.rdata = {st.low_frac, 5'h00};
				RDT_OFS_CRIT_LIMIT: next_st.rdata = st.crit_limit;
				RDT_OFS_CRIT_HYST: next_st.rdata = st.crit_hyst;
				RDT_OFS_FILTER_PIN: next_st.rdata = {5'h00, st.filter_mode, st.cmp_mode};
				default: next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.offset_int <= RDT_RST_OFFSET_INT;
			st.offset_frac <= RDT_RST_FRAC;
			st.high_int <= RDT_RST_HIGH_INT;
			st.high_frac <= RDT_RST_FRAC;
			st.low_int <= RDT_RST_LOW_INT;
			st.low_frac <= RDT_RST_FRAC;
			st.crit_limit <= RDT_RST_CRIT_LIMIT;
			st.crit_hyst <= RDT_RST_CRIT_HYST;
			st.filter_mode <= RDT_RST_FILTER;
			st.cmp_mode <= RDT_RST_CMP_MODE;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign reg_rdata = st.rdata;
	assign remote_high_alarm = st.high_alarm;
	assign remote_low_alarm = st.low_alarm;
	assign remote_crit_alarm = st.crit_alarm;
	assign reading_valid = st.valid;
	assign alert_condition = st.high_alarm | st.low_alarm | st.crit_alarm;
	// Pin pulled low while asserted
	assign alert_pin_o = 1'b0;
	assign alert_pin_oe = st.cmp_mode ? alert_condition : alert_normal;
endmodule : rdt_limits

// file: rtl/rdt_pkg.sv
// Constants for the remote temperature result, offset and limit registers
package rdt_pkg;
	// Register offsets
	localparam logic [7:0] RDT_OFS_READING_INT = 8'h01;
	localparam logic [7:0] RDT_OFS_HIGH_INT = 8'h07;
	localparam logic [7:0] RDT_OFS_LOW_INT = 8'h08;
	localparam logic [7:0] RDT_OFS_READING_FRAC = 8'h10;
	localparam logic [7:0] RDT_OFS_OFFSET_INT = 8'h11;
	localparam logic [7:0] RDT_OFS_OFFSET_FRAC = 8'h12;
	localparam logic [7:0] RDT_OFS_HIGH_FRAC = 8'h13;
	localparam logic [7:0] RDT_OFS_LOW_FRAC = 8'h14;
	localparam logic [7:0] RDT_OFS_CRIT_LIMIT = 8'h19;
	localparam logic [7:0] RDT_OFS_CRIT_HYST = 8'h21;
	localparam logic [7:0] RDT_OFS_FILTER_PIN = 8'hBF;
	// Reset values
	localparam logic [7:0] RDT_RST_HIGH_INT = 8'h46;
	localparam logic [7:0] RDT_RST_LOW_INT = 8'h00;
	localparam logic [2:0] RDT_RST_FRAC = 3'h0;
	localparam logic [7:0] RDT_RST_OFFSET_INT = 8'h00;
	localparam logic [7:0] RDT_RST_CRIT_LIMIT = 8'h55;
	localparam logic [7:0] RDT_RST_CRIT_HYST = 8'h0A;
	localparam logic [1:0] RDT_RST_FILTER = 2'h0;
	localparam logic RDT_RST_CMP_MODE = 1'b0;
	// Field layout of a fractional byte and of the filter/pin register
	localparam int RDT_FRAC_MSB = 7;
	localparam int RDT_FRAC_LSB = 5;
	localparam int RDT_FRAC_W = 3;
	localparam int RDT_TEMP_W = 11;
	localparam int RDT_FILT_MSB = 2;
	localparam int RDT_FILT_LSB = 1;
	localparam int RDT_CMP_BIT = 0;
	// Filter modes
	typedef enum logic [1:0] {
		RDT_FILT_OFF = 2'b00,
		RDT_FILT_MIN_A = 2'b01,
		RDT_FILT_MIN_B = 2'b10,
		RDT_FILT_MAX = 2'b11
	} rdt_filt_e;
	// Filter smoothing shifts
	localparam int RDT_FILT_MIN_SHIFT = 1;
	localparam int RDT_FILT_MAX_SHIFT = 3;
endpackage : rdt_pkg
